/* File: hdl/fep_pcs_top.sv */
// fep_pcs_top: 100m pcs coding, 10m guard logic, mode resolve, regs
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - 100m transmit serialises mac nibbles into a 125 MHz bit stream.
// - transmit symbols are 4b5b coded first, then scrambled.
// - scrambled stream is turned into nrzi before the line driver.
// - receive bit timing is recovered from nrzi transitions at 125 MHz.
// - recovered timing samples nrzi and turns it back into nrz.
// - receive nrz is descrambled first, then 4b5b decoded.
// - decoded receive data goes to the mac as parallel nibbles.
// - scrambling only at 100m; descrambler exactly undoes the scrambler.
// - at 10m the receive clock keeps running between frames.
// - at 10m a short collision pulse follows every sent frame; the code sends none after a frame that ends during lockout.
// - 10m transmit enable high over 20 ms: transmitter off, col high.
// - after lockout, enable low over 250 ms: transmitter on, col low.
// - all clocks derive from the single reference clock.
// - rmii clock mode derives the mac clock at 50 MHz instead.
// - negotiation picks highest common: 100fd, 100hd, 10fd, 10hd.
// - non negotiating partner: mode from detected fixed signalling.
// - negotiation enabled by strap or control bit 12, software changes.
// - negotiation enable after reset follows the strap level.
// - negotiation off: speed from control bit 13, duplex bit 8.
// - strap level loads control bit 12 at reset release.
module fep_pcs_top #(
   parameter int unsigned JAB_CYC = fep_pkg::JAB_CYC_DEF,
   parameter int unsigned REEN_CYC = fep_pkg::REEN_CYC_DEF
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire fep_pkg::fep_axi_req_t s_axi_req,
   output var fep_pkg::fep_axi_rsp_t s_axi_rsp,
   // straps
   input wire logic autoneg_strap_pin,
   input wire logic rmii_clk_mode,
   // mac transmit
   input wire logic mac_tx_en,
   input wire logic [3:0] mac_txd,
   output logic mac_tx_take,
   // mac receive
   output logic mac_rx_clk,
   output logic mac_rx_dv,
   output logic [3:0] mac_rxd,
   output logic mac_rx_stb,
   output logic mac_rx_er,
   output logic mac_col,
   // line side
   output logic line_tx_bit,
   output logic line_tx_stb,
   output logic line_tx_en,
   input wire logic line_rx_nrzi,
   // partner abilities and parallel detect
   input wire logic lp_an_valid,
   input wire logic [3:0] lp_ability,
   input wire logic pd_valid,
   input wire logic pd_is_100
);

   localparam int CW = $clog2(REEN_CYC + 1);

   if (JAB_CYC < 1 || REEN_CYC < JAB_CYC || CW > 31) begin : g_chk
      $error("fep_pcs_top: guard timer counts out of range");
   end

   // ****************************************************************
   // declarations and synchronisers
   // ****************************************************************
   logic [15:0] ctrl_q;
   logic [3:0] adv_q;
   logic strap_done_q, spd_q, dup_q;
   logic an_s1, an_s2, rm_s1, rm_s2, rx_s1, rx_s2, rx_s3;
   logic aw_have_q, w_have_q, wr_fire;
   logic [31:0] awaddr_q, wdata_q, rd_data;
   logic [3:0] wstrb_q;
   logic [1:0] rd_resp;
   logic [8:0] tx_acc_q, tx_sum, rx_acc_q, rx_sum;
   logic tx_tick, rx_tick, scr_bit;
   fep_pkg::fep_tx_state_t tx_st_q;
   logic [4:0] sym_q;
   logic [2:0] tx_bit_q, rx_cnt_q;
   logic [10:0] scr_q, dsc_q;
   logic rx_prev_q, rx_nrz, rx_dat, dec_ok;
   logic [9:0] rx_sh_q, rx_sh_n;
   logic [3:0] dec_nib;
   logic [5:0] div_q, half;
   logic en_prev_q, jab_q;
   logic [CW-1:0] jcnt_q;
   logic [7:0] sqe_q;
   wire logic an_en = ctrl_q[fep_pkg::CTRL_AN_BIT];

   always_ff @(posedge aclk) begin
      an_s1 <= autoneg_strap_pin;
      an_s2 <= an_s1;
      rm_s1 <= rmii_clk_mode;
      rm_s2 <= rm_s1;
      rx_s1 <= line_rx_nrzi;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
   end

   // ****************************************************************
   // axi4-lite slave
   // ****************************************************************
   assign wr_fire = aw_have_q && w_have_q && !s_axi_rsp.bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 32'h0000_0000;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_rsp.awready <= 1'b1;
         s_axi_rsp.wready <= 1'b1;
         s_axi_rsp.bvalid <= 1'b0;
         s_axi_rsp.bresp <= fep_pkg::RESP_OKAY;
      end else begin
         if (s_axi_req.awvalid && s_axi_rsp.awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_req.awaddr;
            s_axi_rsp.awready <= 1'b0;
         end
         if (s_axi_req.wvalid && s_axi_rsp.wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_req.wdata;
            wstrb_q <= s_axi_req.wstrb;
            s_axi_rsp.wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_rsp.bvalid <= 1'b1;
            s_axi_rsp.bresp <= (awaddr_q == fep_pkg::CTRL_OFS ||
                                awaddr_q == fep_pkg::ADV_OFS ||
                                awaddr_q == fep_pkg::STAT_OFS) ?
                               fep_pkg::RESP_OKAY : fep_pkg::RESP_SLVERR;
         end
         if (s_axi_rsp.bvalid && s_axi_req.bready) begin
            s_axi_rsp.bvalid <= 1'b0;
            s_axi_rsp.awready <= 1'b1;
            s_axi_rsp.wready <= 1'b1;
         end
      end
   end

   always_comb begin
      rd_resp = fep_pkg::RESP_OKAY;
      rd_data = 32'h0000_0000;
      if (s_axi_req.araddr == fep_pkg::CTRL_OFS) begin
         rd_data = {16'h0000, ctrl_q};
      end else if (s_axi_req.araddr == fep_pkg::STAT_OFS) begin
         rd_data = {27'h000_0000, strap_done_q, an_en, jab_q, dup_q, spd_q};
      end else if (s_axi_req.araddr == fep_pkg::ADV_OFS) begin
         rd_data = {28'h000_0000, adv_q};
      end else begin
         rd_resp = fep_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rsp.arready <= 1'b1;
         s_axi_rsp.rvalid <= 1'b0;
         s_axi_rsp.rdata <= 32'h0000_0000;
         s_axi_rsp.rresp <= fep_pkg::RESP_OKAY;
      end else if (s_axi_req.arvalid && s_axi_rsp.arready) begin
         s_axi_rsp.arready <= 1'b0;
         s_axi_rsp.rvalid <= 1'b1;
         s_axi_rsp.rdata <= rd_data;
         s_axi_rsp.rresp <= rd_resp;
      end else if (s_axi_rsp.rvalid && s_axi_req.rready) begin
         s_axi_rsp.rvalid <= 1'b0;
         s_axi_rsp.arready <= 1'b1;
      end
   end

   // ****************************************************************
   // control registers and strap load
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= fep_pkg::CTRL_RST;
         adv_q <= fep_pkg::ADV_RST;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         ctrl_q[fep_pkg::CTRL_AN_BIT] <= an_s2;
         strap_done_q <= 1'b1;
      end else if (wr_fire && awaddr_q == fep_pkg::CTRL_OFS) begin
         if (wstrb_q[0]) ctrl_q[7:0] <= wdata_q[7:0];
         if (wstrb_q[1]) ctrl_q[15:8] <= wdata_q[15:8];
      end else if (wr_fire && awaddr_q == fep_pkg::ADV_OFS) begin
         if (wstrb_q[0]) adv_q <= wdata_q[3:0];
      end
   end

   // ****************************************************************
   // mode resolution
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         spd_q <= 1'b1;
         dup_q <= 1'b0;
      end else if (!an_en) begin
         spd_q <= ctrl_q[fep_pkg::CTRL_SPD_BIT];
         dup_q <= ctrl_q[fep_pkg::CTRL_DUP_BIT];
      end else if (lp_an_valid) begin
         if ((adv_q[3] && lp_ability[3]) || (adv_q[2] && lp_ability[2]))
         begin
            spd_q <= 1'b1;
            dup_q <= adv_q[3] && lp_ability[3];
         end else begin
            spd_q <= 1'b0;
            dup_q <= adv_q[1] && lp_ability[1];
         end
      end else if (pd_valid) begin
         spd_q <= pd_is_100;
         dup_q <= 1'b0;
      end
   end

   // ****************************************************************
   // transmit: 4b5b, scrambler, nrzi
   // ****************************************************************
   assign tx_sum = tx_acc_q + fep_pkg::NCO_INC;
   assign tx_tick = tx_sum >= fep_pkg::NCO_MOD;
   assign scr_bit = sym_q[4] ^ scr_q[8] ^ scr_q[10];

   always_ff @(posedge aclk) begin
      if (!aresetn) tx_acc_q <= 9'h000;
      else tx_acc_q <= tx_tick ? tx_sum - fep_pkg::NCO_MOD : tx_sum;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_st_q <= fep_pkg::TX_IDLE;
         sym_q <= fep_pkg::SYM_IDLE;
         tx_bit_q <= 3'h0;
         scr_q <= 11'h000;
         line_tx_bit <= 1'b0;
         line_tx_stb <= 1'b0;
         mac_tx_take <= 1'b0;
      end else begin
         line_tx_stb <= 1'b0;
         mac_tx_take <= 1'b0;
         if (tx_tick && spd_q) begin
            line_tx_stb <= 1'b1;
            scr_q <= {scr_q[9:0], scr_bit};
            line_tx_bit <= line_tx_bit ^ scr_bit;
            if (tx_bit_q == 3'h4) begin
               tx_bit_q <= 3'h0;
               case (tx_st_q)
                  fep_pkg::TX_J: begin
                     sym_q <= fep_pkg::SYM_K;
                     tx_st_q <= fep_pkg::TX_K;
                  end
                  fep_pkg::TX_K, fep_pkg::TX_DATA: begin
                     if (mac_tx_en) begin
                        sym_q <= fep_pkg::ENC_TAB[mac_txd];
                        mac_tx_take <= 1'b1;
                        tx_st_q <= fep_pkg::TX_DATA;
                     end else begin
                        sym_q <= fep_pkg::SYM_T;
                        tx_st_q <= fep_pkg::TX_T;
                     end
                  end
                  fep_pkg::TX_T: begin
                     sym_q <= fep_pkg::SYM_R;
                     tx_st_q <= fep_pkg::TX_R;
                  end
                  default: begin
                     sym_q <= mac_tx_en ? fep_pkg::SYM_J : fep_pkg::SYM_IDLE;
                     tx_st_q <= mac_tx_en ? fep_pkg::TX_J : fep_pkg::TX_IDLE;
                  end
               endcase
            end else begin
               tx_bit_q <= tx_bit_q + 3'h1;
               sym_q <= {sym_q[3:0], 1'b0};
            end
         end
      end
   end

   // ****************************************************************
   // receive: bit recovery, nrz, descrambler, 4b5b decode
   // ****************************************************************
   assign rx_sum = rx_acc_q + fep_pkg::NCO_INC;
   assign rx_tick = (rx_s2 != rx_s3) || rx_sum >= fep_pkg::NCO_MOD;
   assign rx_nrz = rx_s2 ^ rx_prev_q;
   assign rx_dat = rx_nrz ^ dsc_q[8] ^ dsc_q[10];
   assign rx_sh_n = {rx_sh_q[8:0], rx_dat};

   always_comb begin
      dec_ok = 1'b0;
      dec_nib = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (rx_sh_n[4:0] == fep_pkg::ENC_TAB[i]) begin
            dec_ok = 1'b1;
            dec_nib = 4'(i);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) rx_acc_q <= fep_pkg::RX_MID_PHASE;
      else if (rx_sum >= fep_pkg::NCO_MOD)
         rx_acc_q <= rx_sum - fep_pkg::NCO_MOD;
      else rx_acc_q <= rx_sum;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_prev_q <= 1'b0;
         dsc_q <= 11'h000;
         rx_sh_q <= 10'h000;
         rx_cnt_q <= 3'h0;
         mac_rx_dv <= 1'b0;
         mac_rxd <= 4'h0;
         mac_rx_stb <= 1'b0;
         mac_rx_er <= 1'b0;
      end else begin
         mac_rx_stb <= 1'b0;
         mac_rx_er <= 1'b0;
         if (!spd_q) begin
            mac_rx_dv <= 1'b0;
         end else if (rx_tick) begin
            rx_prev_q <= rx_s2;
            dsc_q <= {dsc_q[9:0], rx_nrz};
            rx_sh_q <= rx_sh_n;
            if (!mac_rx_dv) begin
               if (rx_sh_n == {fep_pkg::SYM_J, fep_pkg::SYM_K}) begin
                  mac_rx_dv <= 1'b1;
                  rx_cnt_q <= 3'h0;
               end
            end else if (rx_cnt_q == 3'h4) begin
               rx_cnt_q <= 3'h0;
               if (rx_sh_n[4:0] == fep_pkg::SYM_T) begin
                  mac_rx_dv <= 1'b0;
               end else begin
                  mac_rxd <= dec_nib;
                  mac_rx_er <= !dec_ok;
                  mac_rx_stb <= 1'b1;
               end
            end else begin
               rx_cnt_q <= rx_cnt_q + 3'h1;
            end
         end
      end
   end

   // ****************************************************************
   // mac clock from the reference
   // ****************************************************************
   assign half = rm_s2 ? fep_pkg::RMII_HALF :
                 spd_q ? fep_pkg::MII100_HALF : fep_pkg::MII10_HALF;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q <= 6'h00;
         mac_rx_clk <= 1'b0;
      end else if (div_q >= half - 6'h01) begin
         div_q <= 6'h00;
         mac_rx_clk <= !mac_rx_clk;
      end else begin
         div_q <= div_q + 6'h01;
      end
   end

   // ****************************************************************
   // 10m guard: sqe pulse and lockout
   // ****************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_prev_q <= 1'b0;
         jcnt_q <= '0;
         jab_q <= 1'b0;
         sqe_q <= 8'h00;
         mac_col <= 1'b0;
         line_tx_en <= 1'b1;
      end else begin
         en_prev_q <= mac_tx_en;
         if (mac_tx_en != en_prev_q) jcnt_q <= '0;
         else if (jcnt_q != CW'(REEN_CYC)) jcnt_q <= jcnt_q + 1'b1;
         if (!jab_q && !spd_q && mac_tx_en && jcnt_q == CW'(JAB_CYC))
            jab_q <= 1'b1;
         else if (jab_q && !mac_tx_en && jcnt_q == CW'(REEN_CYC))
            jab_q <= 1'b0;
         if (!spd_q && !jab_q && en_prev_q && !mac_tx_en)
            sqe_q <= fep_pkg::SQE_CYC;
         else if (sqe_q != 8'h00)
            sqe_q <= sqe_q - 8'h01;
         mac_col <= jab_q || sqe_q != 8'h00;
         line_tx_en <= !jab_q;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_jab_trip: assert property (
      !jab_q && !spd_q && mac_tx_en && jcnt_q == CW'(JAB_CYC)
      |=> jab_q ##1 (mac_col && !line_tx_en))
      else $error("lockout did not start");
   a_jab_release: assert property (
      $fell(jab_q) |-> $past(!mac_tx_en) && $past(jcnt_q) == CW'(REEN_CYC))
      else $error("lockout ended early");
   a_sqe_pulse: assert property (
      !spd_q && !jab_q && $fell(mac_tx_en) |=> ##1 mac_col [*8])
      else $error("no sqe pulse after frame");
   a_tx_only_fast: assert property (
      line_tx_stb |-> $past(spd_q))
      else $error("line strobe outside 100m");
   a_nrzi_map: assert property (
      line_tx_stb |-> (line_tx_bit ^ $past(line_tx_bit)) == $past(scr_bit))
      else $error("nrzi mapping wrong");
   a_rx_clk_runs: assert property (
      !spd_q && !rm_s2 |-> ##[1:41] $changed(mac_rx_clk))
      else $error("receive clock stopped");
   a_forced_mode: assert property (
      !an_en && $stable(ctrl_q) |=>
      spd_q == $past(ctrl_q[fep_pkg::CTRL_SPD_BIT]) &&
      dup_q == $past(ctrl_q[fep_pkg::CTRL_DUP_BIT]))
      else $error("forced mode not applied");
   a_an_best: assert property (
      an_en && lp_an_valid && adv_q[3] && lp_ability[3] |=> spd_q && dup_q)
      else $error("highest common mode not picked");
   a_strap_load: assert property (
      $rose(strap_done_q) |-> an_en == $past(an_s2))
      else $error("strap not loaded");
   a_bresp_hold: assert property (
      s_axi_rsp.bvalid && !s_axi_req.bready |=> s_axi_rsp.bvalid)
      else $error("write response dropped");

endmodule : fep_pcs_top
`default_nettype wire

/* File: hdl/fep_pkg.sv */
// fep_pkg: shared constants, types and register map of the phy core
package fep_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] STAT_OFS = 32'h0000_0004;
   localparam logic [31:0] ADV_OFS = 32'h0000_0008;
   localparam int CTRL_DUP_BIT = 8;
   localparam int CTRL_AN_BIT = 12;
   localparam int CTRL_SPD_BIT = 13;
   localparam logic [15:0] CTRL_RST = 16'h3000;
   localparam logic [3:0] ADV_RST = 4'hf;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_MHZ = 200;
   localparam int LINE_MHZ = 125;
   localparam int JAB_MS = 20;
   localparam int REEN_MS = 250;
   localparam int SQE_NS = 1000;
   localparam int JAB_CYC_DEF = JAB_MS * CLK_MHZ * 1000;
   localparam int REEN_CYC_DEF = REEN_MS * CLK_MHZ * 1000;
   localparam logic [7:0] SQE_CYC = 8'(SQE_NS * CLK_MHZ / 1000);
   localparam logic [8:0] NCO_INC = 9'(LINE_MHZ);
   localparam logic [8:0] NCO_MOD = 9'(CLK_MHZ);
   // receive phase trails transmit by the three-flop line path
   localparam logic [8:0] RX_MID_PHASE =
      9'((CLK_MHZ - (3 * LINE_MHZ) % CLK_MHZ) % CLK_MHZ);
   localparam logic [5:0] MII10_HALF = 6'(CLK_MHZ * 10 / (2 * 25));
   localparam logic [5:0] MII100_HALF = 6'(CLK_MHZ / (2 * 25));
   localparam logic [5:0] RMII_HALF = 6'(CLK_MHZ / (2 * 50));

   // ****************************************************************
   // line symbols
   // ****************************************************************
   localparam logic [4:0] SYM_IDLE = 5'h1f;
   localparam logic [4:0] SYM_J = 5'h18;
   localparam logic [4:0] SYM_K = 5'h11;
   localparam logic [4:0] SYM_T = 5'h0d;
   localparam logic [4:0] SYM_R = 5'h07;
   localparam logic [4:0] ENC_TAB [16] = '{
      5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_J = 3'b001,
      TX_K = 3'b010,
      TX_DATA = 3'b011,
      TX_T = 3'b100,
      TX_R = 3'b101
   } fep_tx_state_t;

   typedef struct packed {
      logic awvalid;
      logic [31:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [31:0] araddr;
      logic rready;
   } fep_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } fep_axi_rsp_t;

endpackage : fep_pkg

/* File: testbench/fep_mac_model.sv */
// fep_mac_model: mac side model that sends and collects nibbles
`timescale 1ns/1ps
`default_nettype none
module fep_mac_model #(
   parameter int LEN = 12
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bench control
   input wire logic tx_go,
   // mac transmit
   output logic mac_tx_en,
   output var logic [3:0] mac_txd,
   input wire logic mac_tx_take,
   // mac receive
   input wire logic mac_rx_dv,
   input wire logic [3:0] mac_rxd,
   input wire logic mac_rx_stb,
   input wire logic mac_rx_er
);
   logic [3:0] sent_q [$];
   logic [3:0] rcvd_q [$];
   int n_sent;
   int n_err;

   assign mac_tx_en = tx_go && (n_sent < LEN);

   // ****************************************************************
   // transmit: nibble held until taken; idle data never stands still
   // ****************************************************************
   always @(posedge aclk) begin
      if (!aresetn || !tx_go) begin
         n_sent <= 0;
      end else if (mac_tx_take) begin
         sent_q.push_back(mac_txd);
         n_sent <= n_sent + 1;
      end
      if (!aresetn) begin
         mac_txd <= 4'h5;
      end else if (mac_tx_take) begin
         mac_txd <= 4'($urandom);
      end else if (!mac_tx_en) begin
         mac_txd <= ~mac_txd;
      end
   end

   // receive: collect strobed nibbles, count code errors
   always @(posedge aclk) begin
      if (mac_rx_stb && mac_rx_dv) begin
         rcvd_q.push_back(mac_rxd);
      end
      if (mac_rx_stb && mac_rx_er) begin
         n_err <= n_err + 1;
      end
   end
endmodule : fep_mac_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// tb_top: self-checking bench of the phy core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int JAB = 50;
   localparam int REEN = 300;
   localparam int LEN = 12;
   logic aclk, aresetn, strap, rmii, go, lpv, pdv, pd100;
   logic [3:0] lpa, v;
   fep_pkg::fep_axi_req_t req;
   fep_pkg::fep_axi_rsp_t rsp;
   wire logic tx_en, take, rx_clk, dv, stb, er, col, tbit, tstb, ten;
   wire logic [3:0] txd, rxd;
   int n_mismatch, comparisons, i, k, n;
   logic [31:0] rd, d;
   logic [1:0] rs;

   fep_pcs_top #(.JAB_CYC(JAB), .REEN_CYC(REEN)) i_fep_pcs_top (
      .aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
      .autoneg_strap_pin(strap), .rmii_clk_mode(rmii), .mac_tx_en(tx_en),
      .mac_txd(txd), .mac_tx_take(take), .mac_rx_clk(rx_clk),
      .mac_rx_dv(dv), .mac_rxd(rxd), .mac_rx_stb(stb), .mac_rx_er(er),
      .mac_col(col), .line_tx_bit(tbit), .line_tx_stb(tstb),
      .line_tx_en(ten), .line_rx_nrzi(tbit), .lp_an_valid(lpv),
      .lp_ability(lpa), .pd_valid(pdv), .pd_is_100(pd100));

   fep_mac_model #(.LEN(LEN)) i_fep_mac_model (
      .aclk(aclk), .aresetn(aresetn), .tx_go(go), .mac_tx_en(tx_en),
      .mac_txd(txd), .mac_tx_take(take), .mac_rx_dv(dv), .mac_rxd(rxd),
      .mac_rx_stb(stb), .mac_rx_er(er));

   initial begin
      aclk = 1'h0;
      forever #2.5 aclk = ~aclk;
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic results;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results

   task automatic tmo;
      n_mismatch++;
      results();
   endtask : tmo

   task automatic rst(input logic s);
      aresetn <= 1'h0;
      strap <= s;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (3) @(posedge aclk);
   endtask : rst

   task automatic axw(input logic [31:0] a, input logic [31:0] dat);
      req.awvalid <= 1'h1;
      req.awaddr <= a;
      req.wvalid <= 1'h1;
      req.wdata <= dat;
      req.wstrb <= 4'hf;
      req.bready <= 1'h1;
      for (int j = 0; j < 100; j++) begin
         @(posedge aclk);
         if (rsp.awready) req.awvalid <= 1'h0;
         if (rsp.wready) req.wvalid <= 1'h0;
         if (rsp.bvalid) begin
            rs = rsp.bresp;
            req.bready <= 1'h0;
            return;
         end
      end
      tmo();
   endtask : axw

   task automatic axr(input logic [31:0] a);
      req.arvalid <= 1'h1;
      req.araddr <= a;
      req.rready <= 1'h1;
      for (int j = 0; j < 100; j++) begin
         @(posedge aclk);
         if (rsp.arready) req.arvalid <= 1'h0;
         if (rsp.rvalid) begin
            rd = rsp.rdata;
            rs = rsp.rresp;
            req.rready <= 1'h0;
            return;
         end
      end
      tmo();
   endtask : axr

   // cycles between two rising edges of the receive clock
   task automatic per(output int c);
      int r0;
      logic p;
      r0 = -1;
      p = rx_clk;
      for (int j = 0; j < 400; j++) begin
         @(posedge aclk);
         if (rx_clk && !p) begin
            if (r0 >= 0) begin
               c = j - r0;
               return;
            end
            r0 = j;
         end
         p = rx_clk;
      end
      tmo();
   endtask : per

   // {full, speed100} of the best common mode
   function automatic logic [1:0] best(input logic [3:0] c);
      if (c[3]) return 2'h3;
      if (c[2]) return 2'h1;
      if (c[1]) return 2'h2;
      return 2'h0;
   endfunction : best

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      req = '0;
      aresetn = 1'h0;
      strap = 1'h1;
      rmii = 1'h0;
      go = 1'h0;
      lpv = 1'h0;
      lpa = 4'h0;
      pdv = 1'h0;
      pd100 = 1'h0;
      n_mismatch = 0;
      comparisons = 0;
      void'($urandom(32'h36cc_be58));
      rst(1'h1);
      axr(fep_pkg::CTRL_OFS);
      chk(rd, 32'h0000_3000);
      axr(fep_pkg::ADV_OFS);
      chk(rd, 32'h0000_000f);
      axr(32'h0000_0040);
      chk(32'(rs), 32'(fep_pkg::RESP_SLVERR));
      axw(32'h0000_0040, 32'h0000_0000);
      chk(32'(rs), 32'(fep_pkg::RESP_SLVERR));
      lpv <= 1'h1;
      for (i = 0; i < 9; i++) begin
         v = (i == 0) ? 4'h1 : 4'($urandom_range(15, 1));
         lpa <= v;
         repeat (20) @(posedge aclk);
         axr(fep_pkg::STAT_OFS);
         chk(32'(rd[3:0]), {28'h0, 2'h2, best(v)});
      end
      lpv <= 1'h0;
      pdv <= 1'h1;
      for (i = 0; i < 2; i++) begin
         pd100 <= i[0];
         repeat (20) @(posedge aclk);
         axr(fep_pkg::STAT_OFS);
         chk(32'(rd[3:0]), {28'h0, 3'h4, i[0]});
      end
      for (i = 0; i < 4; i++) begin
         d = (32'(i[1]) << 13) | (32'(i[0]) << 8);
         axw(fep_pkg::CTRL_OFS, d);
         repeat (20) @(posedge aclk);
         axr(fep_pkg::CTRL_OFS);
         chk(rd, d);
         axr(fep_pkg::STAT_OFS);
         chk(32'(rd[3:0]), {28'h0, 2'h0, i[0], i[1]});
      end
      per(n);
      chk(n, 2 * fep_pkg::MII100_HALF);
      rmii <= 1'h1;
      repeat (20) @(posedge aclk);
      per(n);
      chk(n, 2 * fep_pkg::RMII_HALF);
      rmii <= 1'h0;
      n = 0;
      repeat (1000) begin
         @(posedge aclk);
         if (tstb) n++;
      end
      chk(n, 625);
      go <= 1'h1;
      for (k = 0; k < 3000 && i_fep_mac_model.n_sent != LEN; k++)
         @(posedge aclk);
      if (k == 3000) tmo();
      go <= 1'h0;
      repeat (400) @(posedge aclk);
      chk(i_fep_mac_model.rcvd_q.size(), LEN);
      for (k = 0; k < LEN; k++)
         chk(i_fep_mac_model.rcvd_q[k], i_fep_mac_model.sent_q[k]);
      chk(i_fep_mac_model.n_err, 0);
      axw(fep_pkg::CTRL_OFS, 32'h0000_0000);
      repeat (20) @(posedge aclk);
      per(n);
      chk(n, 2 * fep_pkg::MII10_HALF);
      go <= 1'h1;
      repeat (10) @(posedge aclk);
      go <= 1'h0;
      n = 0;
      repeat (600) begin
         @(posedge aclk);
         if (col) n++;
      end
      chk(n, 32'(fep_pkg::SQE_CYC));
      go <= 1'h1;
      repeat (JAB - 5) @(posedge aclk);
      chk({col, ten}, 2'h1);
      repeat (15) @(posedge aclk);
      chk({col, ten}, 2'h2);
      go <= 1'h0;
      repeat (REEN - 5) @(posedge aclk);
      chk({col, ten}, 2'h2);
      repeat (15) @(posedge aclk);
      chk({col, ten}, 2'h1);
      rst(1'h0);
      axr(fep_pkg::CTRL_OFS);
      chk(rd, 32'h0000_2000);
      axr(fep_pkg::STAT_OFS);
      chk(32'(rd[3]), 32'h0000_0000);
      results();
   end
endmodule : tb_top
`default_nettype wire
